// ---- logic/vic_consts.svh ----
// Offsets, field positions, reset values and counts for the vectored interrupt controller.
// Assumes it is included by bare name from the package and the design file.
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH
`define VIC_NUM_REQ       118
`define VIC_REQ_W         7
`define VIC_VEC_OFFSET    7'h08
`define VIC_IVT_BASE      24'h000014
`define VIC_IVT_LAST      24'h0000FE
`define VIC_ALTERNATE_VECTOR_TABLE_BASE     24'h000114
`define VIC_ALTERNATE_VECTOR_TABLE_LAST     24'h0001FE
`define VIC_NUM_REGS      27
`define VIC_LVL_W         3
`define VIC_CPU_LVL_W     4
`define VIC_LVL_MAX       3'h7
`define VIC_LVL_NONE      3'h0
`define VIC_REQ_MODULATOR_SPECIAL_EVENT      7'h39
`define VIC_REQ_SER_ERR   7'h41
`define VIC_REQ_ADC_PAIR0 7'h6E
`define VIC_REQ_ADC_PAIR6 7'h74
`define VIC_REQ_LAST_RSVD 7'h75
// Mask of request numbers with a source attached; reserved slots are zero.
`define VIC_IMPL_MASK     118'h1F_C383_C000_0002_0200_0000_201F_3FEF
`endif

// ---- logic/vic_pkg.sv ----
// Types shared by the vectored interrupt controller.
// Assumes vic_consts.svh is on the include path.
`include "vic_consts.svh"
package vic_pkg;
  typedef logic [`VIC_NUM_REQ-1:0]   vic_req_vec_t;
  typedef logic [`VIC_LVL_W-1:0]     vic_lvl_t;
  typedef logic [`VIC_CPU_LVL_W-1:0] vic_cpu_lvl_t;
  typedef logic [6:0]                vic_latched_vector_number_t;
  typedef logic [23:0]               vic_addr_t;
endpackage

// ---- logic/vic_ctrl.sv ----
// Vectored interrupt controller: flags, enables, levels, arbitration and vector latch.
// Assumes synchronous inputs on clk; flag clears arrive as per-bit strobes, enable and level writes as one strobe with data.
`include "vic_consts.svh"
module vic_ctrl #(
  parameter int NUM_REQ = `VIC_NUM_REQ
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Peripheral request pulses and software flag access.
  input  wire vic_pkg::vic_req_vec_t req_set,
  input  wire vic_pkg::vic_req_vec_t flag_clr,
  // Software enable and level programming.
  input  wire logic                enable_we,
  input  wire vic_pkg::vic_req_vec_t enable_wdata,
  input  wire logic                level_we,
  input  wire logic [6:0]          level_idx,
  input  wire vic_pkg::vic_lvl_t   level_wdata,
  // Global controls and CPU level.
  input  wire logic                nesting_disable,
  input  wire logic                alt_table_sel,
  input  wire logic                cpu_lvl_we,
  input  wire vic_pkg::vic_lvl_t   cpu_lvl_wdata,
  input  wire logic                core_top_set,
  input  wire logic                core_top_clr,
  // Read-back state.
  output vic_pkg::vic_req_vec_t    request_flag_regs,
  output vic_pkg::vic_req_vec_t    request_enable_regs,
  output vic_pkg::vic_cpu_lvl_t    cpu_priority_level,
  // Vector presented to the core.
  output logic                     irq_pending,
  output vic_pkg::vic_latched_vector_number_t     latched_vector_number,
  output vic_pkg::vic_cpu_lvl_t    latched_new_level,
  output vic_pkg::vic_addr_t       vector_addr
);
  import vic_pkg::*;

  localparam vic_req_vec_t IMPL = `VIC_IMPL_MASK;

  vic_req_vec_t flag_q;
  vic_req_vec_t en_q;
  vic_lvl_t     lvl_q [NUM_REQ];
  vic_lvl_t     cpu_lvl_q;
  logic         cpu_top_q;
  logic         irq_q;
  vic_latched_vector_number_t  vec_q;
  vic_cpu_lvl_t ilr_q;
  vic_addr_t    addr_q;

  // Sticky flags; a set arriving with its clear wins so no event is lost.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= '0;
    end else begin
      flag_q <= ((flag_q & ~flag_clr) | req_set) & IMPL;
    end
  end

  // Enable bits, one per source; reserved slots stay zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= '0;
    end else if (enable_we) begin
      en_q <= enable_wdata & IMPL;
    end
  end

  // Level fields in table order; request n owns slot n.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_REQ; i++) lvl_q[i] <= `VIC_LVL_NONE;
    end else if (level_we && level_idx < 7'(NUM_REQ)) begin
      lvl_q[level_idx] <= level_wdata;
    end
  end

  // CPU level: low bits locked while nesting is off; top bit is core-owned only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_lvl_q <= `VIC_LVL_NONE;
      cpu_top_q <= 1'b0;
    end else begin
      if (cpu_lvl_we && !nesting_disable) cpu_lvl_q <= cpu_lvl_wdata;
      if (core_top_set) cpu_top_q <= 1'b1;
      else if (core_top_clr) cpu_top_q <= 1'b0;
    end
  end

  // Arbitration: scanning downward with >= lets lower numbers win ties.
  // The scan is one long priority chain over every source; it costs no flops but sets the
  // longest path in the block, so the winner is registered before the core sees it.
  logic        win_any;
  logic [6:0]  win_idx;
  vic_lvl_t    win_lvl;
  logic        blocked;
  always_comb begin
    win_any = 1'b0;
    win_idx = '0;
    win_lvl = `VIC_LVL_NONE;
    blocked = cpu_top_q || (cpu_lvl_q == `VIC_LVL_MAX);
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (flag_q[i] && en_q[i] && lvl_q[i] != `VIC_LVL_NONE
          && lvl_q[i] > cpu_lvl_q && (!win_any || lvl_q[i] >= win_lvl)) begin
        win_any = 1'b1;
        win_idx = 7'(i);
        win_lvl = lvl_q[i];
      end
    end
    if (blocked) win_any = 1'b0;
  end

  // Vector status latch and table address; address is base plus twice the request.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q  <= 1'b0;
      vec_q  <= '0;
      ilr_q  <= '0;
      addr_q <= '0;
    end else begin
      irq_q <= win_any;
      if (win_any) begin
        vec_q  <= win_idx + `VIC_VEC_OFFSET;
        ilr_q  <= {1'b0, win_lvl};
        addr_q <= (alt_table_sel ? `VIC_ALTERNATE_VECTOR_TABLE_BASE : `VIC_IVT_BASE)
                  + {16'h0000, win_idx, 1'b0};
      end
    end
  end

  // Read-back views; with the control inputs they stand in for the software register groups.
  assign request_flag_regs     = flag_q;
  assign request_enable_regs   = en_q;
  assign cpu_priority_level    = {cpu_top_q, cpu_lvl_q};
  assign irq_pending           = irq_q;
  assign latched_vector_number = vec_q;
  assign latched_new_level     = ilr_q;
  assign vector_addr           = addr_q;

  // Checks on the latch and arbitration.
  AST_VEC_OFFSET: assert property (@(posedge clk) disable iff (!rst_b)
    win_any |=> latched_vector_number == $past(win_idx) + `VIC_VEC_OFFSET)
    else $error("vector number is not request plus eight");
  AST_LEVEL_MATCH: assert property (@(posedge clk) disable iff (!rst_b)
    win_any |=> latched_new_level[2:0] == lvl_q[$past(win_idx)] || $past(level_we))
    else $error("latched level differs from chosen level");
  AST_BLOCK_TOP: assert property (@(posedge clk) disable iff (!rst_b)
    (cpu_top_q || cpu_lvl_q == `VIC_LVL_MAX) |-> !win_any)
    else $error("request passed while user level blocked");
  AST_ZERO_LVL: assert property (@(posedge clk) disable iff (!rst_b)
    win_any |-> lvl_q[win_idx] != `VIC_LVL_NONE && lvl_q[win_idx] > cpu_lvl_q)
    else $error("winner level not above cpu level");
  AST_QUALIFY: assert property (@(posedge clk) disable iff (!rst_b)
    win_any |-> flag_q[win_idx] && en_q[win_idx])
    else $error("winner lacks flag or enable");

  // Table addresses: the exact slot, and never outside the chosen table.
  AST_PRIMARY: assert property (@(posedge clk) disable iff (!rst_b)
    (win_any && !alt_table_sel) |=> vector_addr <= `VIC_IVT_LAST
      && vector_addr == `VIC_IVT_BASE + {16'h0000, $past(win_idx), 1'b0})
    else $error("primary address out of table");
  AST_ALT: assert property (@(posedge clk) disable iff (!rst_b)
    (win_any && alt_table_sel) |=> vector_addr >= `VIC_ALTERNATE_VECTOR_TABLE_BASE && vector_addr <= `VIC_ALTERNATE_VECTOR_TABLE_LAST
      && vector_addr == `VIC_ALTERNATE_VECTOR_TABLE_BASE + {16'h0000, $past(win_idx), 1'b0})
    else $error("alternate address out of table");

  // Flag, enable and level storage.
  AST_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
    (flag_q[0] && !flag_clr[0]) |=> flag_q[0])
    else $error("flag dropped without clear");
  AST_CLEAR_ONE: assert property (@(posedge clk) disable iff (!rst_b)
    (flag_clr[1] && !req_set[1]) |=> !flag_q[1])
    else $error("flag survived a clear with no new event");
  AST_RSVD_EMPTY: assert property (@(posedge clk) disable iff (!rst_b)
    ((flag_q | en_q) & ~IMPL) == '0)
    else $error("reserved slot holds a flag or enable");
  AST_EN_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !enable_we |=> en_q == $past(en_q))
    else $error("enable bits changed without a write");
  AST_LVL_SLOT: assert property (@(posedge clk) disable iff (!rst_b)
    (level_we && level_idx < 7'(NUM_REQ)) |=> lvl_q[$past(level_idx)] == $past(level_wdata))
    else $error("level write did not land in its slot");

  // CPU level ownership.
  AST_NEST_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
    nesting_disable |=> cpu_lvl_q == $past(cpu_lvl_q))
    else $error("cpu level changed while nesting disabled");
  AST_TOP_OWNED: assert property (@(posedge clk) disable iff (!rst_b)
    (!core_top_set && !core_top_clr) |=> cpu_top_q == $past(cpu_top_q))
    else $error("top cpu level bit moved without the core");

  // Presentation to the core: a clean request is a set pulse, a held flag, then the vector.
  sequence vic_seq_clean_req;
    req_set[1] && en_q[1] && !cpu_top_q && lvl_q[1] > cpu_lvl_q
      && !enable_we && !level_we && !cpu_lvl_we && !core_top_set;
  endsequence
  sequence vic_seq_flag_then_irq;
    flag_q[1] ##1 irq_pending;
  endsequence
  AST_WALK_ONE: assert property (@(posedge clk) disable iff (!rst_b)
    vic_seq_clean_req |=> vic_seq_flag_then_irq)
    else $error("clean request was not presented two cycles later");
  AST_IRQ_DROP: assert property (@(posedge clk) disable iff (!rst_b)
    !win_any |=> !irq_pending)
    else $error("core still sees a request after arbitration lost it");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !win_any |=> latched_vector_number == $past(latched_vector_number)
      && latched_new_level == $past(latched_new_level))
    else $error("vector status changed with no winner");
endmodule // vic_ctrl

// ---- verification/vic_periph_model.sv ----
// Peripheral side model: turns a request number into a one-cycle set pulse.
// Assumes the bench drives fire and num just after a rising edge of clk.
module vic_periph_model (
  // Clock and command.
  input  wire logic                  clk,
  input  wire logic                  fire,
  input  wire logic [6:0]            num,
  // Set pulses towards the controller.
  output vic_pkg::vic_req_vec_t      req_set
);
  import vic_pkg::*;
  // One pulse per event; the controller's flag must hold it afterwards.
  always_ff @(posedge clk) req_set <= fire ? (vic_req_vec_t'(1) << num) : '0;
endmodule // vic_periph_model

// ---- verification/test_vectored_interrupt_controller.sv ----
// Self-checking bench for the vectored interrupt controller.
// Assumes the peripheral model in vic_periph_model.sv and the constants header.
`include "vic_consts.svh"
module test_vectored_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import vic_pkg::*;
  logic         clk = 0, rst_b = 0, fire = 0, en_we = 0, lv_we = 0, nest = 0;
  logic         alt = 0, cpu_we = 0, top_set = 0, top_clr = 0, irq;
  logic [6:0]   num = 0, lv_idx = 0;
  vic_lvl_t     lv_data = 0, cpu_data = 0;
  vic_req_vec_t req_set, clr = '0, en_data = '0, flags, ens;
  vic_cpu_lvl_t cpu_lvl, new_lvl;
  vic_latched_vector_number_t  vnum;
  vic_addr_t    vaddr;
  int           mismatches = 0, num_checks = 0, cycles = 0;
  vic_periph_model periph_u (.clk(clk), .fire(fire), .num(num), .req_set(req_set));
  vic_ctrl dut_u (.clk(clk), .rst_b(rst_b), .req_set(req_set), .flag_clr(clr),
    .enable_we(en_we), .enable_wdata(en_data), .level_we(lv_we), .level_idx(lv_idx),
    .level_wdata(lv_data), .nesting_disable(nest), .alt_table_sel(alt),
    .cpu_lvl_we(cpu_we), .cpu_lvl_wdata(cpu_data), .core_top_set(top_set),
    .core_top_clr(top_clr), .request_flag_regs(flags), .request_enable_regs(ens),
    .cpu_priority_level(cpu_lvl), .irq_pending(irq), .latched_vector_number(vnum),
    .latched_new_level(new_lvl), .vector_addr(vaddr));
  // Free-running clock at 25 MHz.
  initial forever #20 clk = ~clk;
  // A hang is cut short well past the hundred or so cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Waiting lets the edge's updates land before anything is sampled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic req(input logic [6:0] n);
    @(posedge clk) begin fire <= 1; num <= n; end
    @(posedge clk) fire <= 0;
    tick(3);
  endtask
  task automatic set_lvl(input logic [6:0] i, input vic_lvl_t l);
    @(posedge clk) begin lv_we <= 1; lv_idx <= i; lv_data <= l; end
    @(posedge clk) lv_we <= 0;
  endtask
  task automatic cpu_wr(input vic_lvl_t l);
    @(posedge clk) begin cpu_we <= 1; cpu_data <= l; end
    @(posedge clk) cpu_we <= 0;
    tick(2);
  endtask
  task automatic clear_all();
    @(posedge clk) clr <= '1;
    @(posedge clk) clr <= '0;
    tick(2);
  endtask
  task automatic t_walk();
    set_lvl(7'h01, 3'h3);
    req(7'h01);
    chk(irq, 1'h1);
    chk(vnum, 7'h09);
    chk(new_lvl, 4'h3);
    chk(vaddr, 24'h000016);
    @(posedge clk) alt <= 1;
    tick(2);
    chk(vaddr, 24'h000116);
    @(posedge clk) alt <= 0;
    clear_all();
    chk(flags[1], 1'h0);
  endtask
  task automatic t_prio();
    set_lvl(7'h39, 3'h5);
    set_lvl(7'h41, 3'h5);
    req(7'h41);
    req(7'h39);
    chk(vnum, 7'h41);
    set_lvl(7'h41, 3'h6);
    tick(3);
    chk(vnum, 7'h49);
    chk(vaddr, 24'h000096);
    set_lvl(7'h74, 3'h7);
    req(7'h74);
    chk({vnum, vaddr}, {7'h7C, 24'h0000FC});
    clear_all();
  endtask
  task automatic t_block();
    req(7'h04);
    req(7'h75);
    chk({flags[117], flags[4]}, 2'h0);
    req(7'h00);
    chk({flags[0], irq}, 2'h2);
    set_lvl(7'h00, 3'h7);
    cpu_wr(3'h7);
    chk({cpu_lvl, irq}, 5'h0E);
    @(posedge clk) nest <= 1;
    cpu_wr(3'h0);
    chk(cpu_lvl, 4'h7);
    @(posedge clk) nest <= 0;
    cpu_wr(3'h0);
    chk({irq, vnum, new_lvl}, 12'h887);
    @(posedge clk) top_set <= 1;
    @(posedge clk) top_set <= 0;
    tick(2);
    chk({cpu_lvl, irq}, 5'h10);
    @(posedge clk) top_clr <= 1;
    @(posedge clk) top_clr <= 0;
    tick(2);
    chk({cpu_lvl, irq}, 5'h01);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset, enable every source, then run each scenario in turn.
  initial begin
    tick(5);
    chk({irq, vnum, flags}, '0);
    @(posedge clk) rst_b <= 1;
    @(posedge clk) begin en_we <= 1; en_data <= '1; end
    @(posedge clk) en_we <= 0;
    tick(1);
    chk(ens, `VIC_IMPL_MASK);
    t_walk();
    t_prio();
    t_block();
    complete_run();
  end
endmodule // test_vectored_interrupt_controller
